// file: verilog/fpes_pkg.sv
// Purpose: Shared constants and types for the flash sequencer and security
// Assumes: 14-bit CPU address space, 8-bit data
// Notes:   Page select register offset is a local choice
package fpes_pkg;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam logic [13:0] ADDR_DX       = 14'h000e;
  localparam logic [13:0] ADDR_PAGE_SEL = 14'h001f;
  localparam logic [13:0] ADDR_WOPT     = 14'h0208;
  localparam logic [13:0] ADDR_FCR      = 14'h0209;
  localparam logic [13:0] ADDR_SOB      = 14'h3ffc;
  localparam logic [13:0] RAM0_HI       = 14'h000e;
  localparam logic [13:0] RAM1_LO       = 14'h0050;
  localparam logic [13:0] RAM1_HI       = 14'h00bf;
  localparam logic [13:0] RAM2_LO       = 14'h0100;
  localparam logic [13:0] RAM2_HI       = 14'h017f;
  localparam logic [13:0] WIN_LO        = 14'h00c0;
  localparam logic [13:0] WIN_HI        = 14'h00ff;
  localparam logic [13:0] FLASH_LO      = 14'h1000;
  localparam logic        RAM_HAS_THIRD = 1'b1;

  // ****************************************************************
  // RAM storage layout
  // ****************************************************************
  localparam int unsigned RAM_DEPTH = 255;
  localparam logic [7:0]  RAM1_BASE = 8'h0f;
  localparam logic [7:0]  RAM2_BASE = 8'h7f;

  // ****************************************************************
  // Register fields and reset values
  // ****************************************************************
  localparam int unsigned FCR_PGM  = 0;
  localparam int unsigned FCR_MASS = 2;
  localparam int unsigned FCR_HV   = 3;
  localparam int unsigned OPT_SEC  = 0;
  localparam int unsigned ROW_LSB  = 6;
  localparam logic [7:0]  PAGE_SEL_RST = 8'h00;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;

  typedef enum logic [3:0]
  {
    SEQ_IDLE    = 4'h1,
    SEQ_ARMED   = 4'h2,
    SEQ_LATCHED = 4'h4,
    SEQ_HIGH    = 4'h8
  } fpes_seq_t;

endpackage

// file: verilog/fpes_ram_if.sv
// Purpose: Carrier between the controller and its RAM store
// Assumes: Single port, combinational read of flip-flop storage
// Notes:   None
`timescale 1ns/1ps
`default_nettype none
interface fpes_ram_if;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic       we;
  logic [7:0] rdata;
  modport ctrl  (output idx, output wdata, output we, input rdata);
  modport store (input idx, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// file: verilog/fpes_sync2.sv
// Purpose: Two flip-flop synchroniser for a pin level
// Assumes: Input is asynchronous to core_clk_i
// Notes:   No reset, so a strap level is seen while reset is held
`timescale 1ns/1ps
`default_nettype none
module fpes_sync2
(
  input  wire logic core_clk_i,
  input  wire logic d_i,
  output logic      q_o
);
  typedef struct packed
  {
    logic ff1;
    logic ff2;
  } fpes_sync_st_t;

  fpes_sync_st_t st;
  fpes_sync_st_t next_st;

  always_comb
  begin
    next_st.ff1 = d_i;
    next_st.ff2 = st.ff1;
  end

  always_ff @(posedge core_clk_i)
  begin
    st <= next_st;
  end

  assign q_o = st.ff2;
endmodule
`default_nettype wire

// file: verilog/fpes_ram.sv
// Purpose: RAM store held in flip-flops
// Assumes: Index already mapped from the CPU address
// Notes:   Never cleared, so contents survive reset and low-power modes
`timescale 1ns/1ps
`default_nettype none
module fpes_ram
  import fpes_pkg::*;
(
  input  wire logic    core_clk_i,
  fpes_ram_if.store    ram
);
  typedef struct packed
  {
    logic [RAM_DEPTH-1:0][7:0] mem;
  } fpes_ram_st_t;

  fpes_ram_st_t st;
  fpes_ram_st_t next_st;

  always_comb
  begin
    next_st = st;
    if (ram.we && (ram.idx < 8'(RAM_DEPTH)))
    begin
      next_st.mem[ram.idx] = ram.wdata;
    end
  end

  // No reset and no clock gate here: data is kept across wait/stop
  always_ff @(posedge core_clk_i)
  begin
    st <= next_st;
  end

  assign ram.rdata = (ram.idx < 8'(RAM_DEPTH)) ? st.mem[ram.idx] : ZERO_BYTE;
endmodule
`default_nettype wire

// file: verilog/fpes_top.sv
// Purpose: Flash program/erase control, option load, security and RAM
// Assumes: reset_i held at least 3 edges; flash_rdata_i follows
//          flash_addr_o in the same cycle
// Notes:   Delay times between steps are timed by software, not here
//
// How it works
// - RAM keeps its contents through wait and stop modes.
// - RAM byte $0E reached through D[X] with X=$0E or $CE page 0.
// - RAM at $0000-$000D, $0050-$00BF and $0100-$017F.
// - Programming works on aligned 64-byte rows.
// - Setting program_select arms capture of a flash write's address/data.
// - Secured: debug or pin-enabled flash reads are blocked and return zero.
// - Every reset copies the stored option byte into the working register.
// - Security code bit 1 unsecured, 0 secured from next reset.
// - Mass erase then any reset removes security.
// - Secured normal boot clears debug_pin_enable and blocks debug.
// - Working option bits 7..1 read 0; writes ignored.
// - Debug controller can mass erase through the flash control register, except after a secured normal boot.
// - High voltage sets only with a select bit and correct sequence.
// - program_select and mass_erase_select never both set.
// - Secured: writes to program_select ignored.
// - page_select supplies address bits 6..13 through the window.
`timescale 1ns/1ps
`default_nettype none
module fpes_top
  import fpes_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic [13:0] bus_addr_i,
  input  wire logic [7:0]  bus_wdata_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  input  wire logic        bus_debug_i,
  input  wire logic [7:0]  index_reg_i,
  input  wire logic        debug_pin_enable_i,
  input  wire logic        mode_select_pin_i,
  input  wire logic [7:0]  flash_rdata_i,
  output logic [7:0]       bus_rdata_o,
  output logic [13:0]      flash_addr_o,
  output logic             flash_prog_o,
  output logic [13:0]      flash_prog_addr_o,
  output logic [7:0]       flash_prog_data_o,
  output logic             flash_erase_o,
  output logic             flash_hv_o,
  output logic [7:0]       flash_ctrl_o,
  output logic             secured_o,
  output logic             debug_pin_clear_o,
  output logic             debug_block_o
);
  import fpes_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed
  {
    logic        program_select;
    logic        mass;
    logic        hv;
    logic        opt_sec;
    logic        normal_boot;
    logic [7:0]  page_sel;
    fpes_seq_t   seq;
    logic [7:0]  row;
    logic [7:0]  rdata;
    logic        prog;
    logic [13:0] prog_addr;
    logic [7:0]  prog_data;
  } fpes_st_t;

  fpes_st_t st;
  fpes_st_t next_st;

  fpes_ram_if ram_bus ();

  logic        mode_q;
  logic [13:0] ind_addr;
  logic [13:0] eff_addr;
  logic        secured;
  logic        dbg_blocked;
  logic        flash_hit;
  logic        ram_hit;
  logic [7:0]  ram_idx;

  fpes_sync2 u_mode_sync
  (
    .core_clk_i (core_clk_i),
    .d_i        (mode_select_pin_i),
    .q_o        (mode_q)
  );

  fpes_ram u_ram
  (
    .core_clk_i (core_clk_i),
    .ram        (ram_bus.store)
  );

  // ****************************************************************
  // Address resolution
  // ****************************************************************
  // Bit value 0 means secured, 1 (erased) means open
  assign secured = ~st.opt_sec;

  // Indirect location takes its address from the index register
  assign ind_addr = (bus_addr_i == ADDR_DX) ? {6'h00, index_reg_i}
                                            : bus_addr_i;

  always_comb
  begin
    eff_addr = ind_addr;
    if ((ind_addr >= WIN_LO) && (ind_addr <= WIN_HI))
    begin
      eff_addr = {st.page_sel, ind_addr[ROW_LSB-1:0]};
    end
  end

  // Three RAM sections packed into one index space
  always_comb
  begin
    ram_hit = 1'b0;
    ram_idx = ZERO_BYTE;
    if (eff_addr <= RAM0_HI)
    begin
      ram_hit = 1'b1;
      ram_idx = eff_addr[7:0];
    end
    else if ((eff_addr >= RAM1_LO) && (eff_addr <= RAM1_HI))
    begin
      ram_hit = 1'b1;
      ram_idx = 8'(eff_addr - RAM1_LO) + RAM1_BASE;
    end
    else if (RAM_HAS_THIRD && (eff_addr >= RAM2_LO) && (eff_addr <= RAM2_HI))
    begin
      ram_hit = 1'b1;
      ram_idx = 8'(eff_addr - RAM2_LO) + RAM2_BASE;
    end
  end

  assign flash_hit = (eff_addr >= FLASH_LO);

  // A secured normal boot shuts the debug link out entirely
  assign dbg_blocked = bus_debug_i && secured && st.normal_boot;

  assign ram_bus.idx   = ram_idx;
  assign ram_bus.wdata = bus_wdata_i;
  assign ram_bus.we    = bus_wr_i && ram_hit && !dbg_blocked;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic w_pgm;
    logic w_mass;
    logic w_hv;
    logic n_pgm;
    logic n_mass;

    w_pgm   = bus_wdata_i[FCR_PGM];
    w_mass  = bus_wdata_i[FCR_MASS];
    w_hv    = bus_wdata_i[FCR_HV];
    n_pgm   = st.program_select;
    n_mass  = st.mass;
    next_st = st;
    next_st.prog = 1'b0;

    if (reset_i)
    begin
      next_st.program_select         = 1'b0;
      next_st.mass        = 1'b0;
      next_st.hv          = 1'b0;
      next_st.page_sel    = PAGE_SEL_RST;
      next_st.seq         = SEQ_IDLE;
      next_st.row         = ZERO_BYTE;
      next_st.rdata       = ZERO_BYTE;
      next_st.prog_addr   = ADDR_SOB;
      next_st.prog_data   = ZERO_BYTE;
      // Option byte reloaded on every reset; erase clears it to 1
      next_st.opt_sec     = flash_rdata_i[OPT_SEC];
      next_st.normal_boot = mode_q;
    end
    else
    begin
      // ************************************************************
      // Reads, answered one cycle later
      // ************************************************************
      if (bus_rd_i)
      begin
        next_st.rdata = ZERO_BYTE;
        if (dbg_blocked)
        begin
          next_st.rdata = ZERO_BYTE;
        end
        else if (ram_hit)
        begin
          next_st.rdata = ram_bus.rdata;
        end
        else if (eff_addr == ADDR_PAGE_SEL)
        begin
          next_st.rdata = st.page_sel;
        end
        else if (eff_addr == ADDR_WOPT)
        begin
          next_st.rdata = {7'h00, st.opt_sec};
        end
        else if (eff_addr == ADDR_FCR)
        begin
          next_st.rdata = flash_ctrl_o;
        end
        else if (flash_hit)
        begin
          // Secure contents hidden from debug and pin-enabled access
          if (secured && (bus_debug_i || debug_pin_enable_i))
          begin
            next_st.rdata = ZERO_BYTE;
          end
          else
          begin
            next_st.rdata = flash_rdata_i;
          end
        end
      end

      // ************************************************************
      // Writes
      // ************************************************************
      if (bus_wr_i && !dbg_blocked)
      begin
        if (eff_addr == ADDR_PAGE_SEL)
        begin
          next_st.page_sel = bus_wdata_i;
        end
        else if (eff_addr == ADDR_FCR)
        begin
          // Debug host reaches this register like the CPU does
          n_pgm  = secured ? st.program_select : w_pgm;
          n_mass = w_mass;
          // Under high voltage selects may only drop: no step skipped
          if (st.seq == SEQ_HIGH)
          begin
            n_pgm  = n_pgm && st.program_select;
            n_mass = n_mass && st.mass;
          end
          if (n_pgm && n_mass)
          begin
            n_pgm  = st.program_select;
            n_mass = st.mass;
          end
          next_st.program_select  = n_pgm;
          next_st.mass = n_mass;
          if (!w_hv)
          begin
            next_st.hv = 1'b0;
          end
          else if (!st.hv && (n_pgm || n_mass) && (st.seq == SEQ_LATCHED))
          begin
            next_st.hv  = 1'b1;
            next_st.seq = SEQ_HIGH;
          end
          if ((st.seq == SEQ_IDLE) && (n_pgm || n_mass))
          begin
            next_st.seq = SEQ_ARMED;
          end
        end
        else if (flash_hit)
        begin
          case (st.seq)
            SEQ_ARMED:
            begin
              // Dummy write picks the row for the rest of the job
              next_st.row = eff_addr[13:ROW_LSB];
              next_st.seq = SEQ_LATCHED;
            end
            SEQ_HIGH:
            begin
              if (st.program_select && st.hv && (eff_addr[13:ROW_LSB] == st.row))
              begin
                next_st.prog      = 1'b1;
                next_st.prog_addr = eff_addr;
                next_st.prog_data = bus_wdata_i;
              end
            end
            default:
            begin
              // Plain array writes are dropped
              next_st.prog = 1'b0;
            end
          endcase
        end
      end

      // Abandoned or finished sequences fall back to idle; other bus
      // traffic between steps leaves the sequence where it is
      if (!next_st.program_select && !next_st.mass && !next_st.hv)
      begin
        next_st.seq = SEQ_IDLE;
      end
      else if ((st.seq != SEQ_HIGH) && !next_st.program_select && !next_st.mass)
      begin
        next_st.seq = SEQ_IDLE;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    st <= next_st;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // During reset the array is pointed at the stored option byte
  assign flash_addr_o      = reset_i ? ADDR_SOB : eff_addr;
  assign bus_rdata_o       = st.rdata;
  assign flash_prog_o      = st.prog;
  assign flash_prog_addr_o = st.prog_addr;
  assign flash_prog_data_o = st.prog_data;
  assign flash_erase_o     = st.mass && st.hv;
  assign flash_hv_o        = st.hv;
  assign flash_ctrl_o      = {4'h0, st.hv, st.mass, 1'b0, st.program_select};
  assign secured_o         = secured;
  assign debug_pin_clear_o = secured && st.normal_boot;
  assign debug_block_o     = secured && st.normal_boot;
endmodule
`default_nettype wire

// file: dv/fpes_top_sva.sv
// Purpose: Port-level assertions for fpes_top
// Assumes: One clock, synchronous active-high reset
// Notes:   Attached by the bind at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module fpes_top_sva
  import fpes_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic [13:0] bus_addr_i,
  input  wire logic [7:0]  bus_wdata_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  input  wire logic        bus_debug_i,
  input  wire logic        debug_pin_enable_i,
  input  wire logic [7:0]  flash_rdata_i,
  input  wire logic [7:0]  bus_rdata_o,
  input  wire logic [13:0] flash_addr_o,
  input  wire logic        flash_prog_o,
  input  wire logic [13:0] flash_prog_addr_o,
  input  wire logic [7:0]  flash_prog_data_o,
  input  wire logic        flash_erase_o,
  input  wire logic [7:0]  flash_ctrl_o,
  input  wire logic        secured_o,
  input  wire logic        debug_pin_clear_o,
  input  wire logic        debug_block_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  chk_erase_start: assert property (
    $rose(flash_erase_o) |-> !$past(flash_ctrl_o[3]))
    else $error("erase started without the high voltage step");
  chk_sel_excl: assert property (
    !(flash_ctrl_o[0] && flash_ctrl_o[2]))
    else $error("both select bits set");
  chk_hv_needs_sel: assert property (
    $rose(flash_ctrl_o[3]) |-> flash_ctrl_o[0] || flash_ctrl_o[2])
    else $error("hv set without a select bit");
  chk_opt_read: assert property (
    bus_rd_i && !bus_debug_i && bus_addr_i == ADDR_WOPT
    |=> bus_rdata_o == {7'h00, ~secured_o})
    else $error("option register read wrong");
  chk_pgm_locked: assert property (
    secured_o && bus_wr_i && bus_addr_i == ADDR_FCR |=> !flash_ctrl_o[0])
    else $error("program select set while secured");
  chk_flash_block: assert property (
    secured_o && bus_rd_i && bus_addr_i >= FLASH_LO
    && (bus_debug_i || debug_pin_enable_i) |=> bus_rdata_o == ZERO_BYTE)
    else $error("secured flash read not blocked");
  chk_opt_load: assert property (
    $fell(reset_i) |-> $past(flash_addr_o) == ADDR_SOB
    && secured_o == ~$past(flash_rdata_i[0]))
    else $error("option byte not loaded at reset");
  chk_prog_cause: assert property (
    flash_prog_o |-> $past(bus_wr_i) && $past(flash_ctrl_o) == 8'h09
    && flash_prog_addr_o[5:0] == 6'($past(bus_addr_i))
    && flash_prog_data_o == $past(bus_wdata_i))
    else $error("program pulse without its cause");
  chk_debug_block: assert property (
    debug_block_o && bus_debug_i && bus_rd_i |=> bus_rdata_o == ZERO_BYTE)
    else $error("debug read not blocked on secured boot");
endmodule

bind fpes_top fpes_top_sva u_sva (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .bus_addr_i(bus_addr_i),
  .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
  .bus_debug_i(bus_debug_i), .debug_pin_enable_i(debug_pin_enable_i),
  .flash_rdata_i(flash_rdata_i), .bus_rdata_o(bus_rdata_o),
  .flash_addr_o(flash_addr_o), .flash_prog_o(flash_prog_o),
  .flash_prog_addr_o(flash_prog_addr_o),
  .flash_prog_data_o(flash_prog_data_o), .flash_erase_o(flash_erase_o),
  .flash_ctrl_o(flash_ctrl_o), .secured_o(secured_o),
  .debug_pin_clear_o(debug_pin_clear_o), .debug_block_o(debug_block_o)
);
`default_nettype wire

// file: dv/fpes_flash_model.sv
// Purpose: Behavioural flash array on the far side of the sequencer
// Assumes: Read data follows the address in the same cycle
// Notes:   Starts erased; programming can only clear bits
`timescale 1ns/1ps
`default_nettype none
module fpes_flash_model
(
  input  wire logic        core_clk_i,
  input  wire logic [13:0] flash_addr_i,
  input  wire logic        flash_prog_i,
  input  wire logic [13:0] flash_prog_addr_i,
  input  wire logic [7:0]  flash_prog_data_i,
  input  wire logic        flash_erase_i,
  output logic [7:0]       flash_rdata_o
);
  logic [7:0] mem [0:16383];
  logic       erase_d = 1'b0;

  initial
  begin
    for (int i = 0; i < 16384; i++)
      mem[i] = 8'hff;
  end

  // Cells change only on a pulse or an erase
  always @(posedge core_clk_i)
  begin
    erase_d <= flash_erase_i;
    if (flash_prog_i)
      mem[flash_prog_addr_i] <= mem[flash_prog_addr_i] & flash_prog_data_i;
    if (flash_erase_i && !erase_d)
      for (int i = 0; i < 16384; i++)
        mem[i] <= 8'hff;
  end

  assign flash_rdata_o = mem[flash_addr_i];
endmodule
`default_nettype wire

// file: dv/fpes_top_tb.sv
// Purpose: Self-checking bench for fpes_top
// Assumes: Inputs driven on the falling edge
// Notes:   Reads and program pulses are checked against queued notes
`timescale 1ns/1ps
`default_nettype none
module fpes_top_tb;
  import fpes_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        reset_i;
  logic        mode_select_pin_i;
  logic [13:0] bus_addr_i = 14'h0000;
  logic [7:0]  bus_wdata_i = 8'h00;
  logic        bus_wr_i = 1'b0;
  logic        bus_rd_i = 1'b0;
  logic        bus_debug_i = 1'b0;
  logic [7:0]  index_reg_i = 8'h00;
  logic        debug_pin_enable_i = 1'b0;
  logic [7:0]  flash_rdata_i, bus_rdata_o, flash_prog_data_o, flash_ctrl_o;
  logic [13:0] flash_addr_o, flash_prog_addr_o;
  logic        flash_prog_o, flash_erase_o, flash_hv_o, secured_o;
  logic        debug_pin_clear_o, debug_block_o;
  logic [7:0]  rd_q [$];
  logic [21:0] pg_q [$];
  logic        rd_d = 1'b0;
  int          miscompares = 0;
  int          comparisons = 0;
  int          seed = 32'h3c11;
  logic [13:0] ram_a [6] = '{14'h0000, 14'h000d, 14'h0050, 14'h00bf,
                              14'h0100, 14'h017f};
  logic [7:0]  ram_d [6];
  logic [7:0]  v;

  always #25 core_clk_i = ~core_clk_i;

  fpes_top u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i),
    .bus_rd_i(bus_rd_i), .bus_debug_i(bus_debug_i),
    .index_reg_i(index_reg_i), .debug_pin_enable_i(debug_pin_enable_i),
    .mode_select_pin_i(mode_select_pin_i), .flash_rdata_i(flash_rdata_i),
    .bus_rdata_o(bus_rdata_o), .flash_addr_o(flash_addr_o),
    .flash_prog_o(flash_prog_o), .flash_prog_addr_o(flash_prog_addr_o),
    .flash_prog_data_o(flash_prog_data_o), .flash_erase_o(flash_erase_o),
    .flash_hv_o(flash_hv_o), .flash_ctrl_o(flash_ctrl_o),
    .secured_o(secured_o), .debug_pin_clear_o(debug_pin_clear_o),
    .debug_block_o(debug_block_o));

  fpes_flash_model u_flash (.core_clk_i(core_clk_i),
    .flash_addr_i(flash_addr_o), .flash_prog_i(flash_prog_o),
    .flash_prog_addr_i(flash_prog_addr_o),
    .flash_prog_data_i(flash_prog_data_o), .flash_erase_i(flash_erase_o),
    .flash_rdata_o(flash_rdata_i));

  task automatic check(input logic [21:0] seen, input logic [21:0] want);
    comparisons++;
    if (seen !== want)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic close_out;
    $display("counts: comparisons=%0d miscompares=%0d", comparisons,
             miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One request per cycle; strobes stay up for back-to-back requests
  task automatic acc(input logic r, input logic w, input logic [13:0] a,
                     input logic [7:0] d);
    bus_rd_i = r;
    bus_wr_i = w;
    bus_addr_i = a;
    bus_wdata_i = d;
    @(negedge core_clk_i);
  endtask

  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    acc(1'b0, 1'b1, a, d);
  endtask

  task automatic rd(input logic [13:0] a, input logic [7:0] want);
    rd_q.push_back(want);
    acc(1'b1, 1'b0, a, 8'h00);
  endtask

  task automatic do_reset(input logic mode);
    reset_i = 1'b1;
    mode_select_pin_i = mode;
    acc(1'b0, 1'b0, 14'h0000, 8'h00);
    repeat (2) @(negedge core_clk_i);
    reset_i = 1'b0;
  endtask

  task automatic program_byte(input logic [7:0] pg, input logic [5:0] off,
                              input logic [7:0] d);
    // No low-power request is ever made inside a sequence
    wr(ADDR_PAGE_SEL, pg);
    wr(ADDR_FCR, 8'h01);
    wr(ADDR_FCR, 8'h09);
    rd(ADDR_FCR, 8'h01);
    wr({8'h03, off}, ~d);
    wr(ADDR_FCR, 8'h05);
    rd(ADDR_FCR, 8'h01);
    wr(ADDR_FCR, 8'h09);
    pg_q.push_back({pg, off, d});
    wr({8'h03, off}, d);
    wr(ADDR_PAGE_SEL, pg + 8'h01);
    wr({8'h03, off}, 8'h00);
    wr(ADDR_PAGE_SEL, pg);
    wr(ADDR_FCR, 8'h08);
    wr(ADDR_FCR, 8'h00);
  endtask

  task automatic mass_erase;
    bus_debug_i = 1'b1;
    wr(ADDR_FCR, 8'h04);
    wr(ADDR_PAGE_SEL, 8'h40);
    wr(WIN_LO, 8'h00);
    wr(ADDR_FCR, 8'h0c);
    rd(ADDR_FCR, 8'h0c);
    check({flash_hv_o, flash_erase_o}, 2'b11);
    wr(ADDR_FCR, 8'h08);
    wr(ADDR_FCR, 8'h0c);
    rd(ADDR_FCR, 8'h08);
    check({flash_hv_o, flash_erase_o}, 2'b10);
    wr(ADDR_FCR, 8'h00);
    check({flash_hv_o, flash_erase_o}, 2'b00);
    bus_debug_i = 1'b0;
  endtask

  always @(posedge core_clk_i)
    rd_d <= bus_rd_i && !reset_i;

  always @(negedge core_clk_i)
  begin
    if (rd_d)
      check(bus_rdata_o, rd_q.pop_front());
    if (flash_prog_o !== 1'b0)
      check({flash_prog_addr_o, flash_prog_data_o}, pg_q.pop_front());
  end

  initial
  begin
    repeat (4000) @(posedge core_clk_i);
    miscompares++;
    close_out();
  end

  initial
  begin
    do_reset(1'b1);
    rd(ADDR_WOPT, 8'h01);
    wr(ADDR_WOPT, 8'h00);
    rd(ADDR_WOPT, 8'h01);
    check(secured_o, 1'b0);
    foreach (ram_a[i])
    begin
      ram_d[i] = 8'($random(seed));
      wr(ram_a[i], ram_d[i]);
    end
    foreach (ram_a[i])
      rd(ram_a[i], ram_d[i]);
    v = 8'($random(seed));
    index_reg_i = 8'h0e;
    wr(ADDR_DX, v);
    wr(ADDR_PAGE_SEL, 8'h00);
    rd(14'h00ce, v);
    rd(14'h0180, 8'h00);
    $display("test ram done");
    v = 8'($random(seed));
    program_byte(8'h80, 6'h05, v);
    rd(14'h2005, v);
    wr(14'h2010, 8'h00);
    rd(14'h2010, 8'hff);
    mass_erase();
    rd(14'h2005, 8'hff);
    $display("test program done");
    program_byte(8'hff, 6'h3c, 8'h00);
    do_reset(1'b1);
    rd(ADDR_WOPT, 8'h00);
    check({debug_block_o, debug_pin_clear_o}, 2'b11);
    wr(ADDR_FCR, 8'h01);
    rd(ADDR_FCR, 8'h00);
    rd(14'h2005, 8'hff);
    rd(ram_a[2], ram_d[2]);
    debug_pin_enable_i = 1'b1;
    rd(14'h2005, 8'h00);
    debug_pin_enable_i = 1'b0;
    bus_debug_i = 1'b1;
    rd(ram_a[2], 8'h00);
    bus_debug_i = 1'b0;
    $display("test secure done");
    do_reset(1'b0);
    check(debug_block_o, 1'b0);
    mass_erase();
    do_reset(1'b1);
    rd(ADDR_WOPT, 8'h01);
    acc(1'b0, 1'b0, 14'h0000, 8'h00);
    @(negedge core_clk_i);
    check(22'(pg_q.size()), 22'h000000);
    $display("test unsecure done");
    close_out();
  end
endmodule
`default_nettype wire
